// File: src/rpf_freq_regs.v
// rpf_freq_regs.v: recovery and programmed-frequency control bytes and
// the selection of the divider pair that drives the cpu synthesizer.
// assumes an smbus slave front end decodes byte writes/reads into
// wr_en/rd_en with an 8-bit command offset; watchdog lives elsewhere.
`timescale 1ns/100ps
`default_nettype none
`include "rpf_map.vh"

module rpf_freq_regs #(
	parameter CODE_W = 5
) (
	input wire clk,
	input wire rst_n,
	input wire wr_en,
	input wire rd_en,
	input wire [7:0] reg_offset,
	input wire [7:0] wr_data,
	input wire watchdog_timeout,
	input wire watchdog_enable,
	input wire ratio_source_override,
	input wire [CODE_W-1:0] latched_strap_code,
	input wire [CODE_W-1:0] software_ratio_code,
	output reg [7:0] rd_data,
	output reg rd_hit,
	output reg [7:0] cpu_divider_n,
	output reg [6:0] cpu_divider_m,
	output reg [1:0] freq_source,
	output reg freq_load,
	output reg recovery_locked,
	output wire [CODE_W-1:0] ratio_code
);

	// ==========================================
	// stored control bytes
	reg [7:0] recovery_divider_n;
	reg [6:0] recovery_divider_m;
	reg recovery_source_select;
	reg [7:0] programmed_divider_n;
	reg [6:0] programmed_divider_m;
	reg programmed_enable;

	// ==========================================
	// command decode and write strobes
	wire hit_rn = (reg_offset == `RPF_OFS_RECOVERY_N);
	wire hit_rm = (reg_offset == `RPF_OFS_RECOVERY_SEL_M);
	wire hit_pn = (reg_offset == `RPF_OFS_PROGRAM_N);
	wire hit_pm = (reg_offset == `RPF_OFS_PROGRAM_EN_M);
	// frequency-changing writes are dropped while locked
	wire freq_wr_ok = wr_en && !recovery_locked;
	wire rec_n_wr = wr_en && hit_rn;
	wire rec_sel_m_wr = wr_en && hit_rm;
	wire prog_n_wr = freq_wr_ok && hit_pn;
	wire prog_m_wr = freq_wr_ok && hit_pm;
	wire rd_mapped = hit_rn || hit_rm || hit_pn || hit_pm;
	wire lock_entry = watchdog_timeout && !recovery_locked;

	// ==========================================
	// next values of the programmed bytes
	// the divider stage reads these, so a load pulse never leaves with the old M
	reg [7:0] next_programmed_n;
	reg [6:0] next_programmed_m;
	reg next_programmed_enable;

	always @* begin
		next_programmed_n = programmed_divider_n;
		next_programmed_m = programmed_divider_m;
		next_programmed_enable = programmed_enable;
		if (prog_n_wr) begin
			next_programmed_n = wr_data;
		end
		if (prog_m_wr) begin
			next_programmed_enable = wr_data[`RPF_EN_BIT];
			next_programmed_m = wr_data[`RPF_M_MSB:0];
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			recovery_divider_n <= `RPF_RST_N;
			recovery_divider_m <= `RPF_RST_M;
			recovery_source_select <= `RPF_RST_BIT;
			programmed_divider_n <= `RPF_RST_N;
			programmed_divider_m <= `RPF_RST_M;
			programmed_enable <= `RPF_RST_BIT;
		end else begin
			// recovery bytes are stored only, even while locked; they count at the next time-out
			if (rec_n_wr) begin
				recovery_divider_n <= wr_data;
			end
			if (rec_sel_m_wr) begin
				recovery_source_select <= wr_data[`RPF_SEL_BIT];
				recovery_divider_m <= wr_data[`RPF_M_MSB:0];
			end
			programmed_divider_n <= next_programmed_n;
			programmed_divider_m <= next_programmed_m;
			programmed_enable <= next_programmed_enable;
		end
	end

	// ==========================================
	// recovery lock: set wins over clear in the same cycle
	// the lock clears only on an edge with the enable low and no time-out
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			recovery_locked <= `RPF_RST_BIT;
		end else if (watchdog_timeout) begin
			recovery_locked <= 1'b1;
		end else if (!watchdog_enable) begin
			recovery_locked <= 1'b0;
		end
	end

	// ==========================================
	// divider selection, registered so outputs come from flops
	// while locked the outputs freeze; a recovery byte written meanwhile waits for the next time-out
	// select zero keeps the programmed pair on the pins, freq_source points the synthesizer at the strap table
	reg [7:0] next_n;
	reg [6:0] next_m;
	reg [1:0] next_src;

	always @* begin
		next_n = next_programmed_n;
		next_m = next_programmed_m;
		next_src = `RPF_SRC_STRAP;
		if (recovery_locked) begin
			next_n = cpu_divider_n;
			next_m = cpu_divider_m;
			next_src = freq_source;
		end else if (watchdog_timeout) begin
			if (recovery_source_select) begin
				next_n = recovery_divider_n;
				next_m = recovery_divider_m;
				next_src = `RPF_SRC_RECOVERY_NM;
			end else begin
				next_src = `RPF_SRC_RECOVERY_STRAP;
			end
		end else if (next_programmed_enable) begin
			next_src = `RPF_SRC_PROGRAM;
		end
	end

	// ==========================================
	// divider outputs and load pulse
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cpu_divider_n <= `RPF_RST_N;
			cpu_divider_m <= `RPF_RST_M;
			freq_source <= `RPF_SRC_STRAP;
		end else begin
			cpu_divider_n <= next_n;
			cpu_divider_m <= next_m;
			freq_source <= next_src;
		end
	end

	// load pulse on an accepted M write, or on entering recovery;
	// an M write fires it even with the enable clear; an N write or an unlock moves the outputs without one
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			freq_load <= `RPF_RST_BIT;
		end else begin
			freq_load <= prog_m_wr || lock_entry;
		end
	end

	// ==========================================
	// read path; unmapped offsets are not claimed
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data <= `RPF_RST_BYTE;
			rd_hit <= `RPF_RST_BIT;
		end else if (rd_en) begin
			rd_hit <= rd_mapped;
			case (reg_offset)
				`RPF_OFS_RECOVERY_N: begin
					rd_data <= recovery_divider_n;
				end
				`RPF_OFS_RECOVERY_SEL_M: begin
					rd_data <= {recovery_source_select, recovery_divider_m};
				end
				`RPF_OFS_PROGRAM_N: begin
					rd_data <= programmed_divider_n;
				end
				`RPF_OFS_PROGRAM_EN_M: begin
					rd_data <= {programmed_enable, programmed_divider_m};
				end
				default: begin
					rd_data <= `RPF_RST_BYTE;
				end
			endcase
		end else begin
			// rd_data keeps the last byte read until the next read strobe
			rd_hit <= 1'b0;
		end
	end

	// ==========================================
	// output ratio
	rpf_ratio_sel #(
		.CODE_W(CODE_W)
	) u_ratio (
		.clk(clk),
		.rst_n(rst_n),
		.ratio_source_override(ratio_source_override),
		.latched_strap_code(latched_strap_code),
		.software_ratio_code(software_ratio_code),
		.ratio_code(ratio_code)
	);

endmodule
`default_nettype wire

// File: include/rpf_map.vh
// rpf_map.vh: byte offsets, field positions and reset values of the
// recovery and programmed-frequency control bytes.
// assumes an smbus byte-command front end delivers offset, data and strobes.
`ifndef RPF_MAP_VH
`define RPF_MAP_VH

// ==========================================
// command byte offsets
`define RPF_OFS_RECOVERY_N 8'h0b
`define RPF_OFS_RECOVERY_SEL_M 8'h0c
`define RPF_OFS_PROGRAM_N 8'h0d
`define RPF_OFS_PROGRAM_EN_M 8'h0e

// ==========================================
// fields
`define RPF_SEL_BIT 7
`define RPF_M_MSB 6
`define RPF_EN_BIT 7

// ==========================================
// reset values
`define RPF_RST_BYTE 8'h00
`define RPF_RST_M 7'h00
`define RPF_RST_N 8'h00
`define RPF_RST_CODE 5'h00
`define RPF_RST_BIT 1'b0

// ==========================================
// source encodings driven on freq_source
`define RPF_SRC_STRAP 2'h0
`define RPF_SRC_PROGRAM 2'h1
`define RPF_SRC_RECOVERY_STRAP 2'h2
`define RPF_SRC_RECOVERY_NM 2'h3

`endif

// File: src/rpf_ratio_sel.v
// rpf_ratio_sel.v: registered choice of the output-ratio code.
// assumes strap code already latched and software select stable in clk domain.
`timescale 1ns/100ps
`default_nettype none
`include "rpf_map.vh"

module rpf_ratio_sel #(
	parameter CODE_W = 5
) (
	input wire clk,
	input wire rst_n,
	input wire ratio_source_override,
	input wire [CODE_W-1:0] latched_strap_code,
	input wire [CODE_W-1:0] software_ratio_code,
	output reg [CODE_W-1:0] ratio_code
);

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ratio_code <= `RPF_RST_CODE;
		end else if (ratio_source_override) begin
			ratio_code <= software_ratio_code;
		end else begin
			ratio_code <= latched_strap_code;
		end
	end

endmodule
`default_nettype wire

// File: sim/rpf_freq_regs_checker.sv
// rpf_freq_regs_checker.sv: port timing checks of rpf_freq_regs.
// assumes one clk domain; bound onto every rpf_freq_regs.
`timescale 1ns/100ps
`default_nettype none
module rpf_freq_regs_checker #(parameter CODE_W = 5) (input wire clk, rst_n, wr_en, rd_en, watchdog_timeout,
	watchdog_enable, ratio_source_override, rd_hit, freq_load, recovery_locked,
	input wire [7:0] reg_offset, wr_data, rd_data, cpu_divider_n, input wire [6:0] cpu_divider_m,
	input wire [1:0] freq_source, input wire [CODE_W-1:0] latched_strap_code, software_ratio_code, ratio_code);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// ==========
	// unlocked writes; skip the cycle after unlock, outputs still settle back then
	sequence s_free_wr(ofs);
		wr_en && reg_offset == ofs && !recovery_locked && !$past(recovery_locked) && !watchdog_timeout;
	endsequence
	sequence s_timeout;
		watchdog_timeout && !recovery_locked;
	endsequence
	a_m_load: assert property (s_free_wr(8'h0e) ##0 wr_data[7] |=> freq_load && freq_source == 2'h1
		&& cpu_divider_m == $past(wr_data[6:0])) else $error("m write gave no load");
	a_n_quiet: assert property (s_free_wr(8'h0d) |=> !freq_load) else $error("n write loaded");
	a_rec_stored: assert property (s_free_wr(8'h0b) |=> !freq_load && $stable(cpu_divider_n))
		else $error("recovery n reached output");
	a_lock_set: assert property (s_timeout |=> recovery_locked && freq_load && freq_source[1])
		else $error("time-out not taken");
	a_lock_hold: assert property (recovery_locked && watchdog_enable |=> recovery_locked) else $error("lock lost");
	a_lock_freeze: assert property (recovery_locked |=> $stable(cpu_divider_n) && $stable(cpu_divider_m)
		&& $stable(freq_source)) else $error("locked output moved");
	a_lock_refuse: assert property (recovery_locked && watchdog_enable && wr_en
		&& (reg_offset == 8'h0d || reg_offset == 8'h0e)
		|=> !freq_load && $stable(cpu_divider_m)) else $error("locked write taken");
	a_ratio_mux: assert property ($past(rst_n) |-> ratio_code ==
		$past(ratio_source_override ? software_ratio_code : latched_strap_code)) else $error("ratio code wrong");
	a_read_map: assert property (rd_en |=> rd_hit == $past(reg_offset >= 8'h0b && reg_offset <= 8'h0e)
		&& (rd_hit || rd_data == 8'h00)) else $error("read decode wrong");
endmodule
bind rpf_freq_regs rpf_freq_regs_checker #(.CODE_W(CODE_W)) i_chk (.*);
`default_nettype wire

// File: sim/rpf_host.sv
// rpf_host.sv: byte-command host driving the control-byte strobes.
// assumes the block takes a strobe on a rising edge of clk.
`timescale 1ns/100ps
`default_nettype none
module rpf_host (input wire logic clk, input wire logic [7:0] rd_data, output logic wr_en = 1'b0,
	output logic rd_en = 1'b0, output logic [7:0] reg_offset = 8'h00, output logic [7:0] wr_data = 8'h00);
	// ==========
	// released lines invert so a stale value is never read as live
	task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
		@(posedge clk);
		wr_en <= 1'b1;
		reg_offset <= ofs;
		wr_data <= d;
		@(posedge clk);
		wr_en <= 1'b0;
		reg_offset <= ~ofs;
		wr_data <= ~d;
	endtask
	task automatic rd(input logic [7:0] ofs, output logic [7:0] d);
		@(posedge clk);
		rd_en <= 1'b1;
		reg_offset <= ofs;
		@(posedge clk);
		rd_en <= 1'b0;
		reg_offset <= ~ofs;
		#1 d = rd_data;
	endtask
endmodule
`default_nettype wire

// File: sim/rpf_freq_regs_tb.sv
// rpf_freq_regs_tb.sv: random and corner runs of rpf_freq_regs.
// assumes rpf_host drives the strobes and the checker is bound.
`timescale 1ns/100ps
`default_nettype none
module rpf_freq_regs_tb;
	logic clk = 1'b0, rst_n = 1'b0, watchdog_timeout = 1'b0, watchdog_enable = 1'b1, ratio_source_override = 1'b0;
	logic wr_en, rd_en, rd_hit, freq_load, recovery_locked, sel;
	logic [4:0] latched_strap_code = 5'h00, software_ratio_code = 5'h00, ratio_code;
	logic [7:0] reg_offset, wr_data, rd_data, cpu_divider_n, d, n, pn;
	logic [6:0] cpu_divider_m, m, pm;
	logic [1:0] freq_source;
	logic [23:0] e;
	int fail_count = 0, checked = 0;
	initial forever #5 clk = ~clk;
	rpf_host i_host (.*);
	rpf_freq_regs #(.CODE_W(5)) i_dut (.*);
	always @(posedge clk) {ratio_source_override, latched_strap_code, software_ratio_code} <= 11'($urandom);
	// ==========
	// expectations and report
	function automatic logic [23:0] exp_out(input logic [7:0] en, input logic [6:0] em, input logic [1:0] es);
		return {en, 1'b0, em, 6'h00, es};
	endfunction
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic test_done;
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	initial begin
		void'($urandom(32'h5d8581c9));
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		for (int a = 11; a <= 14; a++) begin
			i_host.rd(8'(a), d);
			chk({16'h0000, d}, 24'h000000);
		end
		for (int i = 0; i < 4; i++) begin
			{sel, m, n, pm, pn} = 31'($urandom);
			if (i == 0) {sel, n, m} = {1'b1, 8'hff, 7'h7f};
			if (i == 1) sel = 1'b0;
			i_host.wr(8'h0b, n);
			i_host.wr(8'h0c, {sel, m});
			i_host.wr(8'h0d, pn);
			i_host.wr(8'h0e, {1'b1, pm});
			#1 chk(exp_out(cpu_divider_n, cpu_divider_m, freq_source), exp_out(pn, pm, 2'h1));
			i_host.rd(8'h0c, d);
			chk({16'h0000, d}, {16'h0000, sel, m});
			@(posedge clk) watchdog_timeout <= 1'b1;
			@(posedge clk) watchdog_timeout <= 1'b0;
			e = sel ? exp_out(n, m, 2'h3) : exp_out(pn, pm, 2'h2);
			#1 chk(exp_out(cpu_divider_n, cpu_divider_m, freq_source), e);
			chk({23'h000000, recovery_locked}, 24'h000001);
			i_host.wr(8'h0e, {1'b1, ~pm});
			#1 chk(exp_out(cpu_divider_n, cpu_divider_m, freq_source), e);
			i_host.wr(8'h0b, ~n);
			#1 chk(exp_out(cpu_divider_n, cpu_divider_m, freq_source), e);
			@(posedge clk) watchdog_enable <= 1'b0;
			repeat (3) @(posedge clk);
			watchdog_enable <= 1'b1;
			repeat (2) @(posedge clk);
			#1 chk(exp_out(cpu_divider_n, cpu_divider_m, freq_source), exp_out(pn, pm, 2'h1));
			chk({23'h000000, recovery_locked}, 24'h000000);
			i_host.wr(8'h0e, {1'b0, pm});
			#1 chk(exp_out(cpu_divider_n, cpu_divider_m, freq_source), exp_out(pn, pm, 2'h0));
		end
		i_host.rd(8'h20, d);
		chk({16'h0000, d}, 24'h000000);
		test_done;
	end
	initial begin
		#100000;
		fail_count++;
		test_done;
	end
endmodule
`default_nettype wire
